// ===== hdl/audio_clock_defs.vh
// Register offsets, field positions, reset values and clock constants for the clock config block
`ifndef AUDIO_CLOCK_DEFS_VH
`define AUDIO_CLOCK_DEFS_VH

`define ADDR_CTRL_CFG      8'h13
`define ADDR_ROOT_CLOCK_SOURCE_CFG       8'h16
`define ADDR_PDM_DIV       8'h1F
`define ADDR_PDM_EDGE      8'h20
`define ADDR_PIN_CFG       8'h21

`define RST_CTRL_CFG       8'h02
`define RST_ROOT_CLOCK_SOURCE_CFG        8'h10
`define RST_PDM_DIV        8'h40
`define RST_PDM_EDGE       8'h00
`define RST_PIN_CFG        8'h22
`define RST_DIV_CODE       2'h0
`define RST_PIN_FUNC       4'h2
`define RST_PIN_DRIVE      3'h2

// One-hot register select shared by the write and read paths
`define HIT_NONE           5'h00
`define HIT_CTRL           5'h01
`define HIT_ROOT_CLOCK_SOURCE_CFG        5'h02
`define HIT_PDM_DIV        5'h04
`define HIT_PDM_EDGE       5'h08
`define HIT_PIN_CFG        5'h10

`define CTL_TARGET_BIT     7
`define CTL_PLL_BYP_BIT    5
`define CTL_FAMILY_BIT     3
`define SRC_ROOT_BIT       7
`define SRC_MODE_BIT       6
`define SRC_RATIO_MSB      5
`define SRC_RATIO_LSB      3
`define CTL_FREQ_MSB       2
`define CTL_FREQ_LSB       0
`define PDM_DIV_MSB        1
`define PDM_DIV_LSB        0
`define EDGE_PAIR1_BIT     7
`define PIN_FUNC_MSB       7
`define PIN_FUNC_LSB       4
`define PIN_DRV_MSB        2
`define PIN_DRV_LSB        0
`define MASK_CTRL          8'hAF
`define MASK_ROOT_CLOCK_SOURCE_CFG       8'hF8
`define MASK_PDM_EDGE      8'hF0
`define MASK_PIN_CFG       8'hF7

`define ROOT_BIT_CLOCK     1'b0
`define ROOT_REF_CLOCK     1'b1

// PDM clock frequencies; 48 kHz family in kHz, then 44.1 kHz family in Hz
`define PDM_KHZ_48_0       24'd3072
`define PDM_KHZ_48_1       24'd1536
`define PDM_KHZ_48_2       24'd768
`define PDM_KHZ_48_3       24'd6144
`define PDM_HZ_44_0        24'd2822400
`define PDM_HZ_44_1        24'd1411200
`define PDM_HZ_44_2        24'd705600
`define PDM_HZ_44_3        24'd5644800
`define KHZ_TO_HZ          24'd1000

// Reference ratios
`define RATIO_0            12'd64
`define RATIO_1            12'd256
`define RATIO_2            12'd384
`define RATIO_3            12'd512
`define RATIO_4            12'd768
`define RATIO_5            12'd1024
`define RATIO_6            12'd1536
`define RATIO_7            12'd2304

// Reference frequencies in kHz
`define REF_KHZ_0          15'd12000
`define REF_KHZ_1          15'd12288
`define REF_KHZ_2          15'd13000
`define REF_KHZ_3          15'd16000
`define REF_KHZ_4          15'd19200
`define REF_KHZ_5          15'd19680
`define REF_KHZ_6          15'd24000
`define REF_KHZ_7          15'd24576

`endif

// ===== hdl/pdm_pair_capture.v
// One PDM data pin captured on both edges of the PDM clock into two channels
`default_nettype none

module pdm_pair_capture (
	// Clock and reset
	input  wire sys_clk,
	input  wire rst,
	// PDM sampling
	input  wire pdm_clk_rise,
	input  wire pdm_clk_fall,
	input  wire pdm_data,
	input  wire latch_edge,
	// Captured channels
	output reg  odd_chan_reg,
	output reg  even_chan_reg
);

	// Edge 0: odd on falling, even on rising; edge 1 swaps
	wire odd_take  = latch_edge ? pdm_clk_rise : pdm_clk_fall;
	wire even_take = latch_edge ? pdm_clk_fall : pdm_clk_rise;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			odd_chan_reg  <= 1'b0;
			even_chan_reg <= 1'b0;
		end else begin
			if (odd_take)
				odd_chan_reg <= pdm_data;
			if (even_take)
				even_chan_reg <= pdm_data;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/audio_clock_src_pdm_capture_cfg.v
// Clock source, reference ratio, PDM divider and PDM edge configuration with register port
`default_nettype none
`include "audio_clock_defs.vh"

module audio_clock_src_pdm_capture_cfg (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata_reg,
	// PDM inputs
	input  wire        pdm_clk_rise,
	input  wire        pdm_clk_fall,
	input  wire [3:0]  pdm_data,
	// Captured channels, bit 0 is channel 1
	output reg  [7:0]  pdm_chan_reg,
	// Derived clocking
	output reg         controller_mode_reg,
	output reg         pll_enable_reg,
	output reg         root_is_ref_clock_reg,
	output reg  [11:0] ref_ratio_reg,
	output reg         ratio_in_use_reg,
	output reg         freq_from_ratio_reg,
	output reg  [14:0] ref_freq_khz_reg,
	output reg  [23:0] pdm_clock_hz_reg,
	output reg  [1:0]  pdm_clock_divider_reg,
	// Multi-function pin
	output reg  [3:0]  multi_pin_function_reg,
	output reg  [2:0]  multi_pin_drive_reg
);

	reg [7:0] ctrl_cfg_reg;
	reg [7:0] root_clock_source_cfg_reg;
	reg [7:0] pdm_clock_divider_cfg_reg;
	reg [7:0] pdm_input_edge_cfg_reg;
	reg [7:0] multi_pin_config_reg;
	reg [7:0] rdata_next;

	function [11:0] ratio_decode;
		input [2:0] code;
		case (code)
			3'h0: ratio_decode = `RATIO_0;
			3'h1: ratio_decode = `RATIO_1;
			3'h2: ratio_decode = `RATIO_2;
			3'h3: ratio_decode = `RATIO_3;
			3'h4: ratio_decode = `RATIO_4;
			3'h5: ratio_decode = `RATIO_5;
			3'h6: ratio_decode = `RATIO_6;
			default: ratio_decode = `RATIO_7;
		endcase
	endfunction

	function [14:0] freq_decode;
		input [2:0] code;
		case (code)
			3'h0: freq_decode = `REF_KHZ_0;
			3'h1: freq_decode = `REF_KHZ_1;
			3'h2: freq_decode = `REF_KHZ_2;
			3'h3: freq_decode = `REF_KHZ_3;
			3'h4: freq_decode = `REF_KHZ_4;
			3'h5: freq_decode = `REF_KHZ_5;
			3'h6: freq_decode = `REF_KHZ_6;
			default: freq_decode = `REF_KHZ_7;
		endcase
	endfunction

	function [23:0] pdm_decode;
		input [1:0] code;
		input       fam44;
		case (code)
			2'h0: pdm_decode = fam44 ? `PDM_HZ_44_0 : `PDM_KHZ_48_0 * `KHZ_TO_HZ;
			2'h1: pdm_decode = fam44 ? `PDM_HZ_44_1 : `PDM_KHZ_48_1 * `KHZ_TO_HZ;
			2'h2: pdm_decode = fam44 ? `PDM_HZ_44_2 : `PDM_KHZ_48_2 * `KHZ_TO_HZ;
			default: pdm_decode = fam44 ? `PDM_HZ_44_3 : `PDM_KHZ_48_3 * `KHZ_TO_HZ;
		endcase
	endfunction

	// Address decode, shared by the write and read paths
	function [4:0] reg_hit;
		input [7:0] addr;
		if (addr == `ADDR_CTRL_CFG)
			reg_hit = `HIT_CTRL;
		else if (addr == `ADDR_ROOT_CLOCK_SOURCE_CFG)
			reg_hit = `HIT_ROOT_CLOCK_SOURCE_CFG;
		else if (addr == `ADDR_PDM_DIV)
			reg_hit = `HIT_PDM_DIV;
		else if (addr == `ADDR_PDM_EDGE)
			reg_hit = `HIT_PDM_EDGE;
		else if (addr == `ADDR_PIN_CFG)
			reg_hit = `HIT_PIN_CFG;
		else
			reg_hit = `HIT_NONE;
	endfunction

	wire [4:0] addr_hit = reg_hit(reg_addr);

	wire is_ctrl   = ctrl_cfg_reg[`CTL_TARGET_BIT];
	wire pll_byp   = ctrl_cfg_reg[`CTL_PLL_BYP_BIT];
	wire fam44     = ctrl_cfg_reg[`CTL_FAMILY_BIT];
	wire root_ref  = !is_ctrl && pll_byp &&
	                 (root_clock_source_cfg_reg[`SRC_ROOT_BIT] == `ROOT_REF_CLOCK);

	// Field slices, so the decode below carries no bit numbers
	wire [2:0] ratio_code   = root_clock_source_cfg_reg[`SRC_RATIO_MSB:`SRC_RATIO_LSB];
	wire [2:0] freq_code    = ctrl_cfg_reg[`CTL_FREQ_MSB:`CTL_FREQ_LSB];
	wire [1:0] div_code     = pdm_clock_divider_cfg_reg[`PDM_DIV_MSB:`PDM_DIV_LSB];
	wire [3:0] pin_function = multi_pin_config_reg[`PIN_FUNC_MSB:`PIN_FUNC_LSB];
	wire [2:0] pin_drive    = multi_pin_config_reg[`PIN_DRV_MSB:`PIN_DRV_LSB];

	// Register writes; masks keep reserved read-only bits at zero
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_cfg_reg              <= `RST_CTRL_CFG;
			root_clock_source_cfg_reg <= `RST_ROOT_CLOCK_SOURCE_CFG;
			pdm_clock_divider_cfg_reg <= `RST_PDM_DIV;
			pdm_input_edge_cfg_reg    <= `RST_PDM_EDGE;
			multi_pin_config_reg      <= `RST_PIN_CFG;
		end else if (reg_wr) begin
			if (addr_hit == `HIT_CTRL)
				ctrl_cfg_reg <= reg_wdata & `MASK_CTRL;
			else if (addr_hit == `HIT_ROOT_CLOCK_SOURCE_CFG)
				root_clock_source_cfg_reg <= reg_wdata & `MASK_ROOT_CLOCK_SOURCE_CFG;
			else if (addr_hit == `HIT_PDM_DIV)
				pdm_clock_divider_cfg_reg <= reg_wdata;
			else if (addr_hit == `HIT_PDM_EDGE)
				pdm_input_edge_cfg_reg <= reg_wdata & `MASK_PDM_EDGE;
			else if (addr_hit == `HIT_PIN_CFG)
				multi_pin_config_reg <= reg_wdata & `MASK_PIN_CFG;
		end
	end

	// Unmapped addresses read as zero
	always @* begin
		rdata_next = 8'h00;
		if (addr_hit == `HIT_CTRL)
			rdata_next = ctrl_cfg_reg;
		else if (addr_hit == `HIT_ROOT_CLOCK_SOURCE_CFG)
			rdata_next = root_clock_source_cfg_reg;
		else if (addr_hit == `HIT_PDM_DIV)
			rdata_next = pdm_clock_divider_cfg_reg;
		else if (addr_hit == `HIT_PDM_EDGE)
			rdata_next = pdm_input_edge_cfg_reg;
		else if (addr_hit == `HIT_PIN_CFG)
			rdata_next = multi_pin_config_reg;
	end

	// Derived settings are registered so outputs lag a write by one cycle
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg          <= 8'h00;
			controller_mode_reg    <= 1'b0;
			pll_enable_reg         <= 1'b1;
			root_is_ref_clock_reg  <= 1'b0;
			ref_ratio_reg          <= `RATIO_2;
			ratio_in_use_reg       <= 1'b0;
			freq_from_ratio_reg    <= 1'b0;
			ref_freq_khz_reg       <= `REF_KHZ_2;
			pdm_clock_hz_reg       <= `PDM_KHZ_48_0 * `KHZ_TO_HZ;
			pdm_clock_divider_reg  <= `RST_DIV_CODE;
			multi_pin_function_reg <= `RST_PIN_FUNC;
			multi_pin_drive_reg    <= `RST_PIN_DRIVE;
		end else begin
			if (reg_rd)
				reg_rdata_reg <= rdata_next;
			controller_mode_reg   <= is_ctrl;
			pll_enable_reg        <= !pll_byp;
			root_is_ref_clock_reg <= root_ref;
			ref_ratio_reg         <= ratio_decode(ratio_code);
			ratio_in_use_reg      <= is_ctrl || root_ref;
			freq_from_ratio_reg   <= is_ctrl && root_clock_source_cfg_reg[`SRC_MODE_BIT];
			ref_freq_khz_reg      <= freq_decode(freq_code);
			pdm_clock_hz_reg      <= pdm_decode(div_code, fam44);
			pdm_clock_divider_reg <= div_code;
			multi_pin_function_reg <= pin_function;
			multi_pin_drive_reg    <= pin_drive;
		end
	end

	wire [7:0] chan_w;

	// Pair n (1..4) uses edge bit 8-n; ascending bits of chan hold channels 1..8
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_pair
			pdm_pair_capture u_pair (
				.sys_clk       (sys_clk),
				.rst           (rst),
				.pdm_clk_rise  (pdm_clk_rise),
				.pdm_clk_fall  (pdm_clk_fall),
				.pdm_data      (pdm_data[p]),
				.latch_edge    (pdm_input_edge_cfg_reg[`EDGE_PAIR1_BIT-p]),
				.odd_chan_reg  (chan_w[2*p]),
				.even_chan_reg (chan_w[2*p+1])
			);
		end
	endgenerate

	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			pdm_chan_reg <= 8'h00;
		else
			pdm_chan_reg <= chan_w;
	end

endmodule

`default_nettype wire

// ===== test/audio_clock_cfg_asserts.sv
// Port-level assertions for the clock config block
`default_nettype none
module audio_clock_cfg_asserts (
	// Clock and reset
	input wire        sys_clk,
	input wire        rst,
	// Register port
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata_reg,
	// PDM side
	input wire        pdm_clk_rise,
	input wire        pdm_clk_fall,
	input wire [3:0]  pdm_data,
	input wire [7:0]  pdm_chan_reg,
	// Derived clocking
	input wire        controller_mode_reg,
	input wire        pll_enable_reg,
	input wire        root_is_ref_clock_reg,
	input wire [1:0]  pdm_clock_divider_reg
);
	logic [3:0] edge_q;
	// Shadow of the edge bits, updated on the same edge as the design's register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			edge_q <= 4'h0;
		else if (reg_wr && reg_addr == 8'h20)
			edge_q <= reg_wdata[7:4];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Captured bit reaches the channel output two edges after the PDM edge pulse
	property cap(int p);
		pdm_clk_fall != pdm_clk_rise |-> ##2 pdm_chan_reg[2 * p + ($past(edge_q[3 - p], 2)
			^ $past(pdm_clk_rise, 2))] == $past(pdm_data[p], 2);
	endproperty
	a_pair1_edge: assert property (cap(0)) else $error("pair 1 capture edge");
	a_pair2_edge: assert property (cap(1)) else $error("pair 2 capture edge");
	a_pair3_edge: assert property (cap(2)) else $error("pair 3 capture edge");
	a_pair4_edge: assert property (cap(3)) else $error("pair 4 capture edge");
	a_pin_resv_zero: assert property (reg_rd && reg_addr == 8'h21 |=> !reg_rdata_reg[3])
		else $error("pin reserved bit set");
	a_root_ref_only: assert property (root_is_ref_clock_reg |-> !controller_mode_reg
		&& !pll_enable_reg) else $error("reference root outside bypassed target");
	a_div_follows: assert property (reg_wr && reg_addr == 8'h1F |-> ##2
		pdm_clock_divider_reg == $past(reg_wdata[1:0], 2)) else $error("divider stale");
	a_pll_follows: assert property (reg_wr && reg_addr == 8'h13 |-> ##2
		pll_enable_reg == !$past(reg_wdata[5], 2)) else $error("pll enable stale");
	a_mode_follows: assert property (reg_wr && reg_addr == 8'h13 |-> ##2
		controller_mode_reg == $past(reg_wdata[7], 2)) else $error("mode stale");
	c_pin_read: cover property (reg_rd && reg_addr == 8'h21);
	c_ref_root: cover property (root_is_ref_clock_reg);
	c_all_swapped: cover property (pdm_clk_rise && edge_q == 4'hF);
endmodule
bind audio_clock_src_pdm_capture_cfg audio_clock_cfg_asserts u_chk (
	.sys_clk               (sys_clk),
	.rst                   (rst),
	.reg_addr              (reg_addr),
	.reg_wdata             (reg_wdata),
	.reg_wr                (reg_wr),
	.reg_rd                (reg_rd),
	.reg_rdata_reg         (reg_rdata_reg),
	.pdm_clk_rise          (pdm_clk_rise),
	.pdm_clk_fall          (pdm_clk_fall),
	.pdm_data              (pdm_data),
	.pdm_chan_reg          (pdm_chan_reg),
	.controller_mode_reg   (controller_mode_reg),
	.pll_enable_reg        (pll_enable_reg),
	.root_is_ref_clock_reg (root_is_ref_clock_reg),
	.pdm_clock_divider_reg (pdm_clock_divider_reg)
);
`default_nettype wire

// ===== test/pdm_mic_model.sv
// Behavioural PDM microphones: edge pulses and data on four pins
`default_nettype none
module pdm_mic_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	output var  logic       pdm_clk_rise,
	output var  logic       pdm_clk_fall,
	output var  logic [3:0] pdm_data
);
	logic [1:0] phase;
	// Data moves every cycle so a capture on the wrong edge sees another bit
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
			pdm_data <= 4'h0;
		end else begin
			phase <= phase + 2'h1;
			pdm_data <= 4'($urandom);
		end
	end
	assign pdm_clk_rise = phase == 2'h0;
	assign pdm_clk_fall = phase == 2'h2;
endmodule
`default_nettype wire

// ===== test/test_audio_clock_src_pdm_capture_cfg.sv
// Self-checking bench for the clock config block
`default_nettype none
module test_audio_clock_src_pdm_capture_cfg;
	timeunit 1ns;
	timeprecision 100ps;
	logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, e;
	logic [7:0] exp_q[$];
	wire [7:0]  rdata, chan;
	wire [3:0]  pdm, fn;
	wire        rise, fall, ctl, pll, root, in_use, from_ratio;
	wire [11:0] ratio;
	wire [14:0] khz;
	wire [23:0] hz;
	wire [2:0]  drv;
	wire [1:0]  div;
	int         n_errors = 0, checks_done = 0;
	int ratio_t[8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
	int khz_t[8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
	int hz_t[8] = '{3072000, 1536000, 768000, 6144000, 2822400, 1411200, 705600, 5644800};
	always #2 sys_clk = ~sys_clk;
	pdm_mic_model mic (.sys_clk(sys_clk), .rst(rst), .pdm_clk_rise(rise), .pdm_clk_fall(fall),
		.pdm_data(pdm));
	audio_clock_src_pdm_capture_cfg dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(rdata),
		.pdm_clk_rise(rise), .pdm_clk_fall(fall), .pdm_data(pdm), .pdm_chan_reg(chan),
		.controller_mode_reg(ctl), .pll_enable_reg(pll), .root_is_ref_clock_reg(root),
		.ref_ratio_reg(ratio), .ratio_in_use_reg(in_use), .freq_from_ratio_reg(from_ratio),
		.ref_freq_khz_reg(khz), .pdm_clock_hz_reg(hz), .pdm_clock_divider_reg(div),
		.multi_pin_function_reg(fn), .multi_pin_drive_reg(drv));
	task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
		checks_done++;
		if (got !== want) begin
			n_errors++;
			$display("MISMATCH %0t %s got %0h want %0h", $time, what, got, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk) #1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge sys_clk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back(want);
		@(posedge sys_clk) #1;
		reg_rd = 1'b0;
	endtask
	// Derived outputs lag a write by one edge; wait two and look just after the second
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Read data stands from the taking edge, so it is settled by the falling edge
	always @(posedge sys_clk) rd_seen <= reg_rd;
	always @(negedge sys_clk) begin
		if (rd_seen && exp_q.size() != 0)
			chk(rdata, exp_q.pop_front(), "read data");
	end
	initial begin
		#200000;
		n_errors++;
		$display("MISMATCH %0t run limit reached", $time);
		test_done;
	end
	initial begin
		void'($urandom(17));
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		rd(8'h1F, 8'h40);
		rd(8'h20, 8'h00);
		rd(8'h21, 8'h22);
		rd(8'h16, 8'h10);
		rd(8'h30, 8'h00);
		chk(ratio, 384, "reset ratio");
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			e = 8'($urandom);
			wr(8'h20, {i[3:0], e[3:0]});
			repeat (8) @(posedge sys_clk);
			rd(8'h20, {i[3:0], 4'h0});
		end
		e = 8'($urandom);
		wr(8'h21, e);
		rd(8'h21, e & 8'hF7);
		chk({fn, drv}, {e[7:4], e[2:0]}, "pin fields");
		$display("edge and pin done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h13, {4'h0, i[2], 3'h2});
			wr(8'h1F, {6'h10, i[1:0]});
			settle;
			chk(div, i[1:0], "divider");
			chk(hz, hz_t[i], "pdm clock");
		end
		$display("divider done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h13, {5'h10, i[2:0]});
			wr(8'h16, {1'b0, i[0], i[2:0], 3'h0});
			settle;
			chk(ratio, ratio_t[i], "ratio");
			chk(khz, khz_t[i], "ref freq");
			chk({ctl, in_use, from_ratio, pll}, {2'h3, i[0], 1'b1}, "controller");
		end
		$display("ratio done");
		wr(8'h13, 8'h20);
		wr(8'h16, 8'hB8);
		settle;
		chk({root, pll, in_use, from_ratio}, 4'hA, "ref root");
		chk(ratio, 2304, "root ratio");
		wr(8'h16, 8'h00);
		settle;
		chk({root, in_use}, 2'h0, "bit clock root");
		wr(8'h13, 8'hA0);
		wr(8'h16, 8'h80);
		settle;
		chk({root, pll, in_use}, 3'h1, "controller root");
		$display("root source done");
		test_done;
	end
endmodule
`default_nettype wire
